/* File: adt_pkg.sv */
// Package: constants for the converter trigger and result block
package adt_pkg;
   localparam int         RES_W         = 10;
   localparam int         STAT_W        = 4;
   // Register byte offsets
   localparam logic [4:0] ADDR_CTRL0    = 5'h00;
   localparam logic [4:0] ADDR_CTRL1    = 5'h04;
   localparam logic [4:0] ADDR_TRIG     = 5'h08;
   localparam logic [4:0] ADDR_RESH     = 5'h0C;
   localparam logic [4:0] ADDR_RESL     = 5'h10;
   localparam logic [4:0] ADDR_CAP      = 5'h14;
   localparam logic [4:0] ADDR_STAT     = 5'h18;
   localparam logic [4:0] ADDR_MASK     = 5'h1C;
   // Field positions
   localparam int         CTRL0_EN_BIT  = 0;
   localparam int         CTRL0_GO_BIT  = 1;
   localparam int         CTRL0_CHS_LSB = 2;
   localparam int         CTRL1_FMT_BIT = 7;
   localparam int         CTRL1_CKS_LSB = 4;
   localparam int         CTRL1_ALL_BIT = 2;
   localparam int         TRIG_SEL_LSB  = 4;
   localparam int         ST_DONE       = 0;
   localparam int         ST_TMR0       = 1;
   localparam int         ST_TMR1       = 2;
   localparam int         ST_TMR2       = 3;
   // Values after reset
   localparam logic [7:0] REG_RST       = 8'h00;
   localparam logic [3:0] STAT_RST      = 4'h0;
   // Trigger select codes
   localparam logic [2:0] TRIG_NONE     = 3'h0;
   localparam logic [2:0] TRIG_TMR0     = 3'h3;
   localparam logic [2:0] TRIG_TMR1     = 3'h4;
   localparam logic [2:0] TRIG_TMR2     = 3'h5;
   localparam logic [2:0] TRIG_RISE     = 3'h6;
   localparam logic [2:0] TRIG_FALL     = 3'h7;
   // Conversion time
   localparam int         CLK_PERIOD_NS = 8;
   localparam int         CONV_TIME_NS  = 96;
   localparam int         CONV_CYC      =
      (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] CONV_CNT      = 4'(CONV_CYC - 1);
   typedef enum logic {SEQ_IDLE, SEQ_CONV} adt_seq_e;
endpackage : adt_pkg

/* File: adt_conv_if.sv */
// Interface: links between register core, trigger picker and sequencer
`timescale 1ns/10ps
interface adt_conv_if import adt_pkg::*; ();
   logic [2:0]       trig_sel;
   logic             trig_fire;
   logic             enable;
   logic             start;
   logic             abort;
   logic             busy;
   logic             done;
   logic             load;
   logic [RES_W-1:0] result;
   modport ctl  (output trig_sel, enable, start, abort,
                 input  trig_fire, busy, done, load, result);
   modport trig (input trig_sel, output trig_fire);
   modport seq  (input enable, start, abort,
                 output busy, done, load, result);
endinterface : adt_conv_if

/* File: adt_trig_sel.sv */
// Auto-conversion trigger picker
`timescale 1ns/10ps
module adt_trig_sel import adt_pkg::*; (
   input wire logic   ref_clk,
   input wire logic   rst,
   input wire logic   timer0_overflow,
   input wire logic   timer1_overflow,
   input wire logic   timer2_period_match,
   input wire logic   external_trigger_pin,
   adt_conv_if.trig   conv
);
   typedef struct packed {
      logic pin_q;
      logic fire;
   } adt_trig_s;
   adt_trig_s st;
   adt_trig_s next_st;

   always_comb begin
      next_st.pin_q = external_trigger_pin;
      case (conv.trig_sel)
         TRIG_TMR0: next_st.fire = timer0_overflow;     // R02
         TRIG_TMR1: next_st.fire = timer1_overflow;     // R02
         TRIG_TMR2: next_st.fire = timer2_period_match; // R02
         TRIG_RISE: next_st.fire = external_trigger_pin & ~st.pin_q; // R03
         TRIG_FALL: next_st.fire = ~external_trigger_pin & st.pin_q; // R03
         default:   next_st.fire = 1'b0;                // R01
      endcase
      if (rst) begin
         next_st.fire = 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      st <= next_st;
   end

   assign conv.trig_fire = st.fire;
endmodule : adt_trig_sel

/* File: adt_conv_seq.sv */
// Conversion sequencer: timed conversion, abort and result capture
`timescale 1ns/10ps
module adt_conv_seq import adt_pkg::*; (
   input wire logic             ref_clk,
   input wire logic             rst,
   input wire logic [RES_W-1:0] conv_sample,
   adt_conv_if.seq              conv
);
   typedef struct packed {
      adt_seq_e         state;
      logic [3:0]       cnt;
      logic             done;
      logic             load;
      logic [RES_W-1:0] result;
   } adt_seq_s;
   adt_seq_s st;
   adt_seq_s next_st;

   always_comb begin
      next_st      = st;
      next_st.done = 1'b0;
      next_st.load = 1'b0;
      case (st.state)
         SEQ_IDLE: begin
            if (conv.enable && conv.start) begin
               next_st.state = SEQ_CONV;
               next_st.cnt   = CONV_CNT;
            end
         end
         SEQ_CONV: begin
            if (!conv.enable) begin
               next_st.state = SEQ_IDLE;
            end else if (conv.abort) begin
               // Partial result, no done event
               next_st.state  = SEQ_IDLE;
               next_st.load   = 1'b1;
               next_st.result = conv_sample;
            end else if (st.cnt == 4'h0) begin
               next_st.state  = SEQ_IDLE;
               next_st.done   = 1'b1;
               next_st.load   = 1'b1;
               next_st.result = conv_sample;
            end else begin
               next_st.cnt = st.cnt - 4'h1;
            end
         end
         default: next_st.state = SEQ_IDLE;
      endcase
      if (rst) begin
         next_st.state = SEQ_IDLE;
         next_st.cnt   = 4'h0;
         next_st.done  = 1'b0;
         next_st.load  = 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      st <= next_st;
   end

   assign conv.busy   = (st.state == SEQ_CONV);
   assign conv.done   = st.done;
   assign conv.load   = st.load;
   assign conv.result = st.result;
endmodule : adt_conv_seq

/* File: adt_ctrl.sv */
// Converter control: registers, go flag, result packing, interrupts
//
// Overview of operation
// R01 - Trigger select 000, 001, 010 never start a conversion.
// R02 - Select 011/100/101 start on timer0, timer1 overflow, timer2 match.
// R03 - Select 110 starts on pin rising edge, 111 on falling edge.
// R04 - Timer events set their own flags even when used as trigger.
// R05 - Left justified: high byte holds result bits 9 to 2.
// R06 - Left justified: low byte holds bits 1,0 on top, zeros below.
// R07 - Right justified: high byte holds bits 9,8 at bottom, zeros above.
// R08 - Right justified: low byte holds result bits 7 to 0.
// R09 - Hold capacitor is never discharged after a conversion.
// R10 - Software waits an acquisition time after changing channel.
// R11 - Hold capacitance is 15 pF plus the trim register setting.
// R12 - Justify bit: 1 right justified, 0 left justified, zero fill.
// R13 - On completion clear go, set done flag, load both result bytes.
// R14 - Trigger starts conversion like go when enabled; go stays set.
// R15 - Result bytes not reset, kept through reset, software writable.
`timescale 1ns/10ps
module adt_ctrl import adt_pkg::*; (
   input  wire logic             ref_clk,
   input  wire logic             rst,
   input  wire logic [4:0]       avs_address,
   input  wire logic             avs_read,
   input  wire logic             avs_write,
   input  wire logic [31:0]      avs_writedata,
   output logic      [31:0]      avs_readdata,
   output logic                  avs_waitrequest,
   input  wire logic             timer0_overflow,
   input  wire logic             timer1_overflow,
   input  wire logic             timer2_period_match,
   input  wire logic             external_trigger_pin,
   input  wire logic [RES_W-1:0] conv_sample,
   output logic                  irq,
   output logic                  converter_enable,
   output logic                  conversion_go_flag,
   output logic      [4:0]       channel_select,
   output logic                  hold_sample_en,
   output logic      [7:0]       hold_cap_trim
);
   typedef struct packed {
      logic        en;
      logic        go;
      logic [4:0]  chs;
      logic        fmt;
      logic [2:0]  cks;
      logic [1:0]  pref;
      logic [2:0]  trig;
      logic [7:0]  resh;
      logic [7:0]  resl;
      logic [7:0]  cap;
      logic [3:0]  stat;
      logic [3:0]  mask;
      logic        wait_r;
      logic [7:0]  rdata;
      logic        irq;
      logic        hold;
   } adt_ctrl_s;

   adt_ctrl_s st;
   adt_ctrl_s next_st;
   logic      start_c;
   logic      abort_c;

   adt_conv_if conv ();

   adt_trig_sel u_trig (
      .ref_clk              (ref_clk),
      .rst                  (rst),
      .timer0_overflow      (timer0_overflow),
      .timer1_overflow      (timer1_overflow),
      .timer2_period_match  (timer2_period_match),
      .external_trigger_pin (external_trigger_pin),
      .conv                 (conv.trig)
   );

   adt_conv_seq u_seq (
      .ref_clk     (ref_clk),
      .rst         (rst),
      .conv_sample (conv_sample),
      .conv        (conv.seq)
   );

   function automatic logic [7:0] read_mux(
      input adt_ctrl_s  s,
      input logic [4:0] a
   );
      case (a)
         ADDR_CTRL0: read_mux = {1'b0, s.chs, s.go, s.en};
         ADDR_CTRL1: read_mux = {s.fmt, s.cks, 1'b0, s.go, s.pref};
         ADDR_TRIG:  read_mux = {1'b0, s.trig, 4'h0};
         ADDR_RESH:  read_mux = s.resh;
         ADDR_RESL:  read_mux = s.resl;
         ADDR_CAP:   read_mux = s.cap;
         ADDR_STAT:  read_mux = {4'h0, s.stat};
         ADDR_MASK:  read_mux = {4'h0, s.mask};
         default:    read_mux = 8'h00;
      endcase
   endfunction : read_mux

   always_comb begin
      logic       wr;
      logic [7:0] wd;
      logic       sw_set;
      logic       sw_clr;
      logic [3:0] ev;
      logic [3:0] w1c;
      wr      = 1'b0;
      wd      = 8'h00;
      sw_set  = 1'b0;
      sw_clr  = 1'b0;
      ev      = 4'h0;
      w1c     = 4'h0;
      start_c = 1'b0;
      abort_c = 1'b0;
      next_st = st;
      wd      = avs_writedata[7:0];
      // Write takes effect at the edge where waitrequest is low
      wr      = avs_write && !st.wait_r;
      next_st.wait_r = !((avs_read || avs_write) && st.wait_r);
      if (avs_read && st.wait_r) begin
         next_st.rdata = read_mux(st, avs_address);
      end
      sw_set = wr && (((avs_address == ADDR_CTRL0) && wd[CTRL0_GO_BIT])
                  || ((avs_address == ADDR_CTRL1) && wd[CTRL1_ALL_BIT]));
      sw_clr = wr && (avs_address == ADDR_CTRL0) && !wd[CTRL0_GO_BIT];
      w1c    = 4'h0;
      if (wr) begin
         case (avs_address)
            ADDR_CTRL0: begin
               next_st.en  = wd[CTRL0_EN_BIT];
               next_st.chs = wd[CTRL0_CHS_LSB +: 5];
            end
            ADDR_CTRL1: begin
               next_st.fmt  = wd[CTRL1_FMT_BIT];
               next_st.cks  = wd[CTRL1_CKS_LSB +: 3];
               next_st.pref = wd[1:0];
            end
            ADDR_TRIG: next_st.trig = wd[TRIG_SEL_LSB +: 3];
            ADDR_RESH: next_st.resh = wd;          // R15
            ADDR_RESL: next_st.resl = wd;          // R15
            ADDR_CAP:  next_st.cap  = wd;          // R11
            ADDR_STAT: w1c = wd[STAT_W-1:0];
            ADDR_MASK: next_st.mask = wd[STAT_W-1:0];
            default: ;
         endcase
      end
      // Start from software or selected trigger
      start_c = (sw_set || (conv.trig_fire && st.en)) // R14
                && st.en && !st.go;
      abort_c = sw_clr && st.go;
      if (conv.done || sw_clr || !st.en) begin
         next_st.go = 1'b0;                         // R13
      end
      if (start_c) begin
         next_st.go = 1'b1;                         // R14
      end
      // Result packing
      if (conv.load) begin
         if (st.fmt) begin                          // R12
            next_st.resh = {6'h00, conv.result[9:8]}; // R07
            next_st.resl = conv.result[7:0];          // R08
         end else begin
            next_st.resh = conv.result[9:2];          // R05
            next_st.resl = {conv.result[1:0], 6'h00}; // R06
         end
      end
      // Sticky events, set wins over clear
      ev            = 4'h0;
      ev[ST_DONE]   = conv.done;                    // R13
      ev[ST_TMR0]   = timer0_overflow;              // R04
      ev[ST_TMR1]   = timer1_overflow;              // R04
      ev[ST_TMR2]   = timer2_period_match;          // R04
      next_st.stat  = (st.stat & ~w1c) | ev;
      // Sampling switch opens for conversion and while disabled, never discharges
      next_st.hold  = next_st.en && !next_st.go;    // R09
      if (rst) begin
         next_st.en     = REG_RST[0];
         next_st.go     = REG_RST[0];
         next_st.chs    = REG_RST[4:0];
         next_st.fmt    = REG_RST[0];
         next_st.cks    = REG_RST[2:0];
         next_st.pref   = REG_RST[1:0];
         next_st.trig   = REG_RST[2:0];
         next_st.cap    = REG_RST;
         next_st.stat   = STAT_RST;
         next_st.mask   = STAT_RST;
         next_st.wait_r = 1'b1;
         next_st.rdata  = REG_RST;
         next_st.hold   = 1'b0;
         start_c        = 1'b0;
         abort_c        = 1'b0;
      end
      next_st.irq = |(next_st.stat & next_st.mask) && !rst;
   end

   always_ff @(posedge ref_clk) begin
      st <= next_st;
   end

   assign conv.trig_sel      = st.trig;
   assign conv.enable        = st.en;
   assign conv.start         = start_c;
   assign conv.abort         = abort_c;
   assign avs_readdata       = {24'h000000, st.rdata};
   assign avs_waitrequest    = st.wait_r;
   assign irq                = st.irq;
   assign converter_enable   = st.en;
   assign conversion_go_flag = st.go;
   assign channel_select     = st.chs;
   assign hold_sample_en     = st.hold;
   assign hold_cap_trim      = st.cap;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   logic res_wr;
   assign res_wr = avs_write && !st.wait_r
                   && ((avs_address == ADDR_RESH)
                   || (avs_address == ADDR_RESL));
   logic go_wr;
   assign go_wr = avs_write && !st.wait_r
                  && ((avs_address == ADDR_CTRL0)
                  || (avs_address == ADDR_CTRL1));

   chk_done_clears_go: assert property ( // R13
      conv.done && !go_wr |=> !st.go && st.stat[ST_DONE])
      else $error("go not cleared or done flag not set");

   chk_left_high_byte: assert property ( // R05
      conv.load && !st.fmt && !$past(rst) |=> st.resh == $past(conv.result[9:2]))
      else $error("left justified high byte wrong");

   chk_left_low_byte: assert property ( // R06
      conv.load && !st.fmt |=>
      st.resl == {$past(conv.result[1:0]), 6'h00})
      else $error("left justified low byte wrong");

   chk_right_high_byte: assert property ( // R07
      conv.load && st.fmt |=>
      st.resh == {6'h00, $past(conv.result[9:8])})
      else $error("right justified high byte wrong");

   chk_right_low_byte: assert property ( // R08
      conv.load && st.fmt |=> st.resl == $past(conv.result[7:0]))
      else $error("right justified low byte wrong");

   chk_trig_off_codes: assert property ( // R01
      $past(st.trig) < TRIG_TMR0 |-> !conv.trig_fire)
      else $error("reserved trigger code fired");

   chk_timer_trig: assert property ( // R02
      st.trig == TRIG_TMR1 && timer1_overflow |=> conv.trig_fire)
      else $error("timer1 trigger missed");

   chk_pin_falling: assert property ( // R03
      st.trig == TRIG_FALL && $fell(external_trigger_pin)
      |=> conv.trig_fire)
      else $error("falling edge trigger missed");

   chk_timer_flag_set: assert property ( // R04
      timer0_overflow |=> st.stat[ST_TMR0])
      else $error("timer0 flag not set");

   chk_trig_go_busy: assert property ( // R14
      conv.trig_fire && st.en && !st.go && !go_wr
      |=> st.go ##1 conv.busy [*2])
      else $error("trigger did not start conversion");

   chk_timer0_trig: assert property ( // R02
      st.trig == TRIG_TMR0 && timer0_overflow |=> conv.trig_fire)
      else $error("timer0 trigger missed");

   chk_timer2_trig: assert property ( // R02
      st.trig == TRIG_TMR2 && timer2_period_match |=> conv.trig_fire)
      else $error("timer2 trigger missed");

   chk_pin_rising: assert property ( // R03
      st.trig == TRIG_RISE && $rose(external_trigger_pin)
      |=> conv.trig_fire)
      else $error("rising edge trigger missed");

   chk_timer1_flag: assert property ( // R04
      timer1_overflow |=> st.stat[ST_TMR1])
      else $error("timer1 flag not set");

   chk_timer2_flag: assert property ( // R04
      timer2_period_match |=> st.stat[ST_TMR2])
      else $error("timer2 flag not set");

   chk_disabled_no_go: assert property ( // R14
      !st.en |=> !st.go)
      else $error("go set while converter disabled");

   chk_abort_no_done: assert property (
      abort_c |=> !conv.done)
      else $error("aborted conversion raised done");

   chk_irq_level: assert property (
      st.irq == |(st.stat & st.mask))
      else $error("interrupt level does not follow status");

   chk_hold_level: assert property ( // R09
      st.hold == (st.en && !st.go))
      else $error("sampling switch state wrong");

   chk_wait_one_cycle: assert property (
      (avs_read || avs_write) && st.wait_r |=> !st.wait_r)
      else $error("waitrequest did not drop");

   cov_done_left:  cover property (conv.done && !st.fmt);
   cov_done_right: cover property (conv.done && st.fmt);
   cov_trig_start: cover property (conv.trig_fire && start_c);
   cov_abort:      cover property (abort_c && conv.busy);
endmodule : adt_ctrl

/* File: adt_trig_src.sv */
// Partner model: timer event pulses and trigger pin level
`timescale 1ns/10ps
module adt_trig_src (
   input  wire logic       ref_clk,
   input  wire logic       fire,
   input  wire logic [2:0] src,
   output logic            timer0_overflow,
   output logic            timer1_overflow,
   output logic            timer2_period_match,
   output logic            external_trigger_pin
);
   initial begin
      timer0_overflow      = 1'b0;
      timer1_overflow      = 1'b0;
      timer2_period_match  = 1'b0;
      external_trigger_pin = 1'b0;
   end
   // Timer events are single-cycle pulses
   always @(posedge ref_clk) begin
      timer0_overflow     <= fire && src == 3'h0;
      timer1_overflow     <= fire && src == 3'h1;
      timer2_period_match <= fire && src == 3'h2;
      if (fire && src == 3'h3) begin
         external_trigger_pin <= 1'b1;
      end
      if (fire && src == 3'h4) begin
         external_trigger_pin <= 1'b0;
      end
   end
endmodule : adt_trig_src

/* File: tb.sv */
// Testbench: register bus, triggers, result packing, interrupt
`timescale 1ns/10ps
module tb;
   import adt_pkg::*;
   logic             ref_clk, rst, avs_read, avs_write, fire;
   logic [4:0]       avs_address, chan_o;
   logic [31:0]      avs_writedata, avs_readdata;
   logic             avs_waitrequest, irq, en_o, go_o, hse;
   logic [7:0]       trim_o;
   logic [2:0]       src;
   logic [RES_W-1:0] smp;
   logic             t0, t1, t2, pin;
   logic [31:0]      exp_q[$];
   int               err_count, samples_checked, cyc;

   adt_ctrl u_adt_ctrl (
      .ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .timer0_overflow(t0),
      .timer1_overflow(t1), .timer2_period_match(t2),
      .external_trigger_pin(pin), .conv_sample(smp), .irq(irq),
      .converter_enable(en_o), .conversion_go_flag(go_o),
      .channel_select(chan_o), .hold_sample_en(hse),
      .hold_cap_trim(trim_o)
   );
   adt_trig_src u_adt_trig_src (
      .ref_clk(ref_clk), .fire(fire), .src(src), .timer0_overflow(t0),
      .timer1_overflow(t1), .timer2_period_match(t2),
      .external_trigger_pin(pin)
   );

   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen,
                  exp);
      end
   endtask : check

   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : stop_test

   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : tick

   task automatic bus(input logic wr, input logic [4:0] a,
                      input logic [7:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      avs_address   <= a;
      avs_write     <= wr;
      avs_read      <= ~wr;
      avs_writedata <= {24'h0, d};
      do begin
         @(posedge ref_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus

   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      bus(1'b1, a, d);
   endtask : wr

   task automatic rd(input logic [4:0] a, input logic [7:0] e);
      exp_q.push_back({24'h0, e});
      bus(1'b0, a, 8'h00);
   endtask : rd

   task automatic fire_ev(input logic [2:0] s);
      @(posedge ref_clk);
      fire <= 1'b1;
      src  <= s;
      @(posedge ref_clk);
      fire <= 1'b0;
      tick(4);
   endtask : fire_ev

   task automatic wait_go();
      int n;
      n = 0;
      while (go_o !== 1'b0 && n < 40) begin
         @(posedge ref_clk);
         n++;
      end
      tick(2);
   endtask : wait_go

   // Oldest note against data on the bus
   always @(posedge ref_clk) begin
      if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
         if (exp_q.size() > 0) begin
            check(avs_readdata, exp_q.pop_front());
         end
      end
   end

   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         stop_test();
      end
   end

   initial begin
      rst = 1'b1;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 5'h00;
      avs_writedata = 32'h0;
      fire = 1'b0;
      src = 3'h0;
      smp = '0;
      void'($urandom(32'h71EA8044));
      tick(12);
      rst <= 1'b0;
      tick(1);
      for (int i = 0; i < 8; i++) begin
         if (i != 3 && i != 4) rd(5'(i * 4), REG_RST);
      end
      check(irq, 1'b0);
      wr(5'h02, 8'hFF);
      rd(5'h02, 8'h00);
      wr(ADDR_TRIG, 8'hFF);
      rd(ADDR_TRIG, 8'h70);
      wr(ADDR_CAP, 8'h37);
      tick(1);
      check(trim_o, 8'h37);
      $display("test registers done");
      for (int j = 0; j < 2; j++) begin
         smp <= RES_W'($urandom);
         wr(ADDR_MASK, 8'h01);
         wr(ADDR_CTRL1, {j[0], 7'h00});
         wr(ADDR_CTRL0, 8'h29);
         tick(8);
         check(chan_o, 5'h0A);
         check(hse, 1'b1);
         wr(ADDR_CTRL0, 8'h2B);
         tick(2);
         check(go_o, 1'b1);
         check(hse, 1'b0);
         wait_go();
         check(irq, 1'b1);
         rd(ADDR_STAT, 8'h01);
         rd(ADDR_RESH, j ? {6'h00, smp[9:8]} : smp[9:2]);
         rd(ADDR_RESL, j ? smp[7:0] : {smp[1:0], 6'h00});
         check(hse, 1'b1);
         wr(ADDR_MASK, 8'h00);
         tick(2);
         check(irq, 1'b0);
         wr(ADDR_STAT, 8'h01);
         wr(ADDR_MASK, 8'h01);
         tick(2);
         check(irq, 1'b0);
      end
      wr(ADDR_CTRL0, 8'h03);
      tick(3);
      wr(ADDR_CTRL0, 8'h01);
      tick(2);
      check(go_o, 1'b0);
      rd(ADDR_STAT, 8'h00);
      $display("test conversion done");
      wr(ADDR_RESH, 8'hA5);
      rd(ADDR_RESH, 8'hA5);
      rst <= 1'b1;
      tick(2);
      rst <= 1'b0;
      tick(1);
      rd(ADDR_RESH, 8'hA5);
      rd(ADDR_CTRL1, 8'h00);
      $display("test result keep done");
      wr(ADDR_CTRL0, 8'h01);
      for (int c = 0; c < 8; c++) begin
         wr(ADDR_TRIG, {1'b0, c[2:0], 4'h0});
         wr(ADDR_STAT, 8'h0F);
         for (int s = 0; s < 5; s++) begin
            fire_ev(3'(s));
            check(go_o, c == s + 3);
            wait_go();
         end
         rd(ADDR_STAT, c > 2 ? 8'h0F : 8'h0E);
      end
      wr(ADDR_CTRL0, 8'h00);
      wr(ADDR_TRIG, {1'b0, TRIG_TMR0, 4'h0});
      wr(ADDR_STAT, 8'h0F);
      fire_ev(3'h0);
      check(go_o, 1'b0);
      check(en_o, 1'b0);
      rd(ADDR_STAT, 8'h02);
      $display("test triggers done");
      tick(5);
      stop_test();
   end
endmodule : tb
